/* src/cplt_lut_regs.sv */
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - Three palette tables, blue, green and red, each hold 256 entries of 6 bits.
// - Each colour staging register keeps its component in bits 7-2 until the next write to that register; pointer writes leave it.
// - The blue staging register supplies the blue component committed on a pointer write.
// - The green staging register supplies the green component committed on a pointer write.
// - An entry changes only when a write-pointer write completes, taking all staged components.
// - The write pointer is 8 bits, bits 7-0, and selects one entry in all three tables.
// - A write-pointer write loads the same value into the read pointer.
// - Both pointers are write-only and read back as zero.
// - The read pointer is 8 bits and selects the entry shown at the three readback offsets.
// - Each readback register shows its 6-bit component in bits 7-2.
// - Readback registers reload only on a read-pointer or write-pointer write and hold otherwise.
// - Readback registers are read-only; writes to them change nothing.
// - Every register bit clears to zero at reset unless stated otherwise.

module cplt_lut_regs import cplt_pkg::*; (
	input wire logic CLK, // 125 MHz clock
	input wire logic RESET, // Synchronous reset, active high
	input wire logic [ADDR_W-1:0] ADDRESS, // Byte address
	input wire logic READ, // Read request
	input wire logic WRITE, // Write request
	input wire logic [DATA_W-1:0] WRITEDATA, // Write data
	input wire logic [BE_W-1:0] BYTEENABLE, // Byte lanes
	output logic [DATA_W-1:0] READDATA, // Read data
	output logic WAITREQUEST // Stall until access completes
);

	logic wait_r;
	logic [DATA_W-1:0] readdata_r;
	cplt_rgb_t stage_r;
	logic [PTR_W-1:0] rd_ptr_r;
	cplt_rgb_t readback_r;
	cplt_rgb_t mem_rdata;
	logic req;
	logic start;
	logic done;
	logic wr_done;
	logic wptr_done;
	logic rptr_done;
	logic [PTR_W-1:0] ptr_in;
	logic [COLOR_W-1:0] color_in;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
		reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
	endfunction

	function automatic logic [DATA_W-1:0] color_word(input logic [COLOR_W-1:0] c);
		color_word = {24'h00_0000, c, 2'h0};
	endfunction

	// Pointers and staging registers are write-only and read as zero
	function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a,
		input cplt_rgb_t rb);
		read_word = WORD_ZERO;
		if (reg_hit(a, IDX_BLUE_READBACK)) begin
			read_word = color_word(rb.blue);
		end else if (reg_hit(a, IDX_GREEN_READBACK)) begin
			read_word = color_word(rb.green);
		end else if (reg_hit(a, IDX_RED_READBACK)) begin
			read_word = color_word(rb.red);
		end
	endfunction

	assign req = READ || WRITE;
	assign start = req && wait_r;
	assign done = req && !wait_r;
	// Only the low byte lane carries register data
	assign wr_done = done && WRITE && BYTEENABLE[0];
	assign wptr_done = wr_done && reg_hit(ADDRESS, IDX_WRITE_PTR);
	assign rptr_done = wr_done && reg_hit(ADDRESS, IDX_READ_PTR);
	assign ptr_in = WRITEDATA[PTR_LSB +: PTR_W];
	assign color_in = WRITEDATA[COLOR_MSB:COLOR_LSB];

	// Every access takes one wait cycle so read data comes from a register
	always_ff @(posedge CLK) begin
		if (RESET) begin
			wait_r <= 1'b1;
		end else if (start) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			readdata_r <= WORD_ZERO;
		end else if (start && READ) begin
			readdata_r <= read_word(ADDRESS, readback_r);
		end
	end

	// Staged components wait here; the table is untouched until a write-pointer write
	always_ff @(posedge CLK) begin
		if (RESET) begin
			stage_r <= RGB_RST;
		end else if (wr_done) begin
			if (reg_hit(ADDRESS, IDX_BLUE_STAGE)) begin
				stage_r.blue <= color_in;
			end
			if (reg_hit(ADDRESS, IDX_GREEN_STAGE)) begin
				stage_r.green <= color_in;
			end
			if (reg_hit(ADDRESS, IDX_RED_STAGE)) begin
				stage_r.red <= color_in;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rd_ptr_r <= PTR_RST;
		end else if (wptr_done || rptr_done) begin
			rd_ptr_r <= ptr_in;
		end
	end

	// On a commit the table read would be stale, so the staged value is forwarded
	always_ff @(posedge CLK) begin
		if (RESET) begin
			readback_r <= RGB_RST;
		end else if (wptr_done) begin
			readback_r <= stage_r;
		end else if (rptr_done) begin
			readback_r <= mem_rdata;
		end
	end

	cplt_palette_mem #(
		.DEPTH(ENTRY_COUNT)
	) u_mem (
		.clk(CLK),
		.reset(RESET),
		.we(wptr_done),
		.waddr(ptr_in),
		.wdata(stage_r),
		.raddr(ptr_in),
		.rdata(mem_rdata)
	);

	assign READDATA = readdata_r;
	assign WAITREQUEST = wait_r;

	// Checks

	sequence s_start_write(logic [IDX_W-1:0] idx);
		start && WRITE && BYTEENABLE[0] && reg_hit(ADDRESS, idx);
	endsequence

	sequence s_complete_write(logic [IDX_W-1:0] idx);
		s_start_write(idx) ##1 (WRITE && !wait_r && reg_hit(ADDRESS, idx));
	endsequence

	sequence s_start_read(logic [IDX_W-1:0] idx);
		start && READ && reg_hit(ADDRESS, idx);
	endsequence

	property p_wait_cycle;
		@(posedge CLK) disable iff (RESET)
		start |=> !WAITREQUEST ##1 WAITREQUEST;
	endproperty
	a_wait_cycle: assert property (p_wait_cycle)
		else $error("waitrequest did not drop for exactly one cycle");

	property p_stage_hold;
		@(posedge CLK) disable iff (RESET)
		!(wr_done && (reg_hit(ADDRESS, IDX_BLUE_STAGE) || reg_hit(ADDRESS, IDX_GREEN_STAGE)
			|| reg_hit(ADDRESS, IDX_RED_STAGE))) |=> $stable(stage_r);
	endproperty
	a_stage_hold: assert property (p_stage_hold)
		else $error("staged colour changed without a staging write");

	property p_blue_stage;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_BLUE_STAGE) |=> stage_r.blue == $past(WRITEDATA[7:2]);
	endproperty
	a_blue_stage: assert property (p_blue_stage)
		else $error("blue staging value not taken from bits 7-2");

	property p_green_stage;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_GREEN_STAGE) |=> stage_r.green == $past(WRITEDATA[7:2]);
	endproperty
	a_green_stage: assert property (p_green_stage)
		else $error("green staging value not taken from bits 7-2");

	property p_commit_only;
		@(posedge CLK) disable iff (RESET)
		u_mem.we |-> (WRITE && !WAITREQUEST && reg_hit(ADDRESS, IDX_WRITE_PTR));
	endproperty
	a_commit_only: assert property (p_commit_only)
		else $error("table written outside a write-pointer completion");

	property p_commit_entry;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_WRITE_PTR) |=>
			u_mem.table_r[$past(WRITEDATA[7:0])] == $past(stage_r);
	endproperty
	a_commit_entry: assert property (p_commit_entry)
		else $error("committed entry does not hold the staged components");

	property p_read_ptr_follow;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_WRITE_PTR) |=> rd_ptr_r == $past(WRITEDATA[7:0]);
	endproperty
	a_read_ptr_follow: assert property (p_read_ptr_follow)
		else $error("read pointer did not follow the write pointer");

	property p_ptr_read_zero;
		@(posedge CLK) disable iff (RESET)
		(s_start_read(IDX_WRITE_PTR) or s_start_read(IDX_READ_PTR))
			|=> READDATA == WORD_ZERO && !WAITREQUEST;
	endproperty
	a_ptr_read_zero: assert property (p_ptr_read_zero)
		else $error("pointer register read back nonzero");

	property p_readback_load;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_READ_PTR) |=>
			readback_r == u_mem.table_r[$past(WRITEDATA[7:0])];
	endproperty
	a_readback_load: assert property (p_readback_load)
		else $error("readback not loaded from the addressed entry");

	property p_readback_field;
		@(posedge CLK) disable iff (RESET)
		s_start_read(IDX_GREEN_READBACK) |=>
			READDATA == {24'h00_0000, $past(readback_r.green), 2'h0};
	endproperty
	a_readback_field: assert property (p_readback_field)
		else $error("green readback not presented in bits 7-2");

	property p_readback_red_field;
		@(posedge CLK) disable iff (RESET)
		s_start_read(IDX_RED_READBACK) |=>
			READDATA[7:2] == $past(readback_r.red) && READDATA[1:0] == 2'h0;
	endproperty
	a_readback_red_field: assert property (p_readback_red_field)
		else $error("red readback not presented in bits 7-2");

	property p_readback_hold;
		@(posedge CLK) disable iff (RESET)
		!(wptr_done || rptr_done) |=> $stable(readback_r);
	endproperty
	a_readback_hold: assert property (p_readback_hold)
		else $error("readback changed without a pointer write");

	property p_readonly;
		@(posedge CLK) disable iff (RESET)
		(s_complete_write(IDX_BLUE_READBACK) or s_complete_write(IDX_RED_READBACK))
			|=> $stable(readback_r) && $stable(rd_ptr_r) && $stable(stage_r);
	endproperty
	a_readonly: assert property (p_readonly)
		else $error("write to a readback register had an effect");

	property p_reset_clear;
		@(posedge CLK)
		$past(RESET) |-> stage_r == RGB_RST && readback_r == RGB_RST
			&& rd_ptr_r == PTR_RST && READDATA == WORD_ZERO && WAITREQUEST;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("register not cleared by reset");

	// Next access may start back to back or after one idle cycle
	property p_commit_visible;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_WRITE_PTR) ##[1:2] s_start_read(IDX_BLUE_READBACK)
			|=> READDATA[7:2] == u_mem.table_r[rd_ptr_r].blue;
	endproperty
	a_commit_visible: assert property (p_commit_visible)
		else $error("readback does not show the just-committed entry");

	property p_red_stage;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_RED_STAGE) |=> stage_r.red == $past(WRITEDATA[7:2]);
	endproperty
	a_red_stage: assert property (p_red_stage)
		else $error("red staging value not taken from bits 7-2");

	// Upper lanes carry nothing, so such a write must leave every register alone
	sequence s_complete_lane_off;
		start && WRITE && !BYTEENABLE[0] ##1 (WRITE && !wait_r);
	endsequence

	property p_lane_off;
		@(posedge CLK) disable iff (RESET)
		s_complete_lane_off |=> $stable(stage_r) && $stable(rd_ptr_r) && $stable(readback_r);
	endproperty
	a_lane_off: assert property (p_lane_off)
		else $error("write with lane 0 off changed a register");

	property p_readback_blue_field;
		@(posedge CLK) disable iff (RESET)
		s_start_read(IDX_BLUE_READBACK) |=>
			READDATA == {24'h00_0000, $past(readback_r.blue), 2'h0};
	endproperty
	a_readback_blue_field: assert property (p_readback_blue_field)
		else $error("blue readback not presented in bits 7-2");

	property p_read_ptr_load;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_READ_PTR) |=> rd_ptr_r == $past(WRITEDATA[7:0]);
	endproperty
	a_read_ptr_load: assert property (p_read_ptr_load)
		else $error("read pointer not loaded from bits 7-0");

	property p_readback_commit;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_WRITE_PTR) |=> readback_r == $past(stage_r);
	endproperty
	a_readback_commit: assert property (p_readback_commit)
		else $error("readback does not hold the committed components");

	// Reads must be free of side effects
	property p_read_no_effect;
		@(posedge CLK) disable iff (RESET)
		READ && !wait_r |=> $stable(stage_r) && $stable(rd_ptr_r) && $stable(readback_r);
	endproperty
	a_read_no_effect: assert property (p_read_no_effect)
		else $error("register changed on a read");

	property p_commit_blue;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_WRITE_PTR) |=>
			u_mem.table_r[$past(WRITEDATA[7:0])].blue == $past(stage_r.blue);
	endproperty
	a_commit_blue: assert property (p_commit_blue)
		else $error("blue table entry not taken from blue staging");

	property p_commit_green;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_WRITE_PTR) |=>
			u_mem.table_r[$past(WRITEDATA[7:0])].green == $past(stage_r.green);
	endproperty
	a_commit_green: assert property (p_commit_green)
		else $error("green table entry not taken from green staging");

	property p_commit_red;
		@(posedge CLK) disable iff (RESET)
		s_complete_write(IDX_WRITE_PTR) |=>
			u_mem.table_r[$past(WRITEDATA[7:0])].red == $past(stage_r.red);
	endproperty
	a_commit_red: assert property (p_commit_red)
		else $error("red table entry not taken from red staging");

endmodule // cplt_lut_regs

/* src/cplt_pkg.sv */
package cplt_pkg;

	// Palette geometry
	localparam int ENTRY_COUNT = 256;
	localparam int COLOR_W = 6;
	localparam int PTR_W = 8;

	// Bus geometry; byte address is four times the register index
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int IDX_W = 6;

	// Register indices
	localparam logic [IDX_W-1:0] IDX_BLUE_STAGE = 6'h08;
	localparam logic [IDX_W-1:0] IDX_GREEN_STAGE = 6'h09;
	localparam logic [IDX_W-1:0] IDX_RED_STAGE = 6'h0a;
	localparam logic [IDX_W-1:0] IDX_WRITE_PTR = 6'h0b;
	localparam logic [IDX_W-1:0] IDX_BLUE_READBACK = 6'h0c;
	localparam logic [IDX_W-1:0] IDX_GREEN_READBACK = 6'h0d;
	localparam logic [IDX_W-1:0] IDX_RED_READBACK = 6'h0e;
	localparam logic [IDX_W-1:0] IDX_READ_PTR = 6'h0f;

	// Colour field sits in bits 7-2, pointer in bits 7-0
	localparam int COLOR_LSB = 2;
	localparam int COLOR_MSB = 7;
	localparam int PTR_LSB = 0;

	// Reset values
	localparam logic [COLOR_W-1:0] COLOR_RST = 6'h00;
	localparam logic [PTR_W-1:0] PTR_RST = 8'h00;
	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic [COLOR_W-1:0] red;
		logic [COLOR_W-1:0] green;
		logic [COLOR_W-1:0] blue;
	} cplt_rgb_t;

	localparam cplt_rgb_t RGB_RST = '{red: COLOR_RST, green: COLOR_RST, blue: COLOR_RST};

endpackage

/* src/cplt_palette_mem.sv */
`timescale 1ns/1ps

module cplt_palette_mem import cplt_pkg::*; #(
	parameter int DEPTH = ENTRY_COUNT
) (
	input wire logic clk, // Memory clock
	input wire logic reset, // Synchronous, active high
	input wire logic we, // Commit strobe
	input wire logic [PTR_W-1:0] waddr, // Entry to commit
	input wire cplt_rgb_t wdata, // Components to commit
	input wire logic [PTR_W-1:0] raddr, // Entry to look up
	output cplt_rgb_t rdata // Looked-up components
);

	// One word holds all three tables so a commit updates them together
	cplt_rgb_t table_r [DEPTH];

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				table_r[i] <= RGB_RST;
			end
		end else if (we) begin
			table_r[waddr] <= wdata;
		end
	end

	assign rdata = table_r[raddr];

endmodule // cplt_palette_mem

/* verif/cplt_host_model.sv */
`timescale 1ns/1ps

module cplt_host_model import cplt_pkg::*; (
	input wire logic clk, // Bus clock
	output logic [ADDR_W-1:0] address, // Byte address
	output logic read, // Read request
	output logic write, // Write request
	output logic [DATA_W-1:0] writedata, // Write data
	output logic [BE_W-1:0] byteenable, // Byte lanes
	input wire logic [DATA_W-1:0] readdata, // Read data
	input wire logic waitrequest // Slave stall
);
	initial begin
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = '0;
	end

	// Idle address, data and lane lines show the inverse of the last request and read and write drop, so stale values never look valid
	task automatic access(input logic [IDX_W-1:0] idx, input logic rd,
		input logic [DATA_W-1:0] wd, input logic [BE_W-1:0] be, output logic [DATA_W-1:0] rdat);
		@(posedge clk);
		address <= {idx, 2'b00};
		read <= rd;
		write <= !rd;
		writedata <= wd;
		byteenable <= be;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rdat = readdata;
		read <= 1'b0;
		write <= 1'b0;
		address <= ~{idx, 2'b00};
		writedata <= ~wd;
		byteenable <= ~be;
	endtask
endmodule // cplt_host_model

/* verif/cplt_lut_regs_test.sv */
`timescale 1ns/1ps

module cplt_lut_regs_test import cplt_pkg::*; ;
	logic clk;
	logic reset;
	logic [ADDR_W-1:0] address;
	logic read;
	logic write;
	logic [DATA_W-1:0] writedata;
	logic [BE_W-1:0] byteenable;
	logic [DATA_W-1:0] readdata;
	logic waitrequest;
	int miscompares = 0;
	int tests_run = 0;

	cplt_lut_regs uut (.CLK(clk), .RESET(reset), .ADDRESS(address), .READ(read),
		.WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable),
		.READDATA(readdata), .WAITREQUEST(waitrequest));

	cplt_host_model host (.clk(clk), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic finish_test;
		if (miscompares == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] unused;
		host.access(idx, 1'b0, d, 4'hf, unused);
	endtask

	task automatic chk(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] got;
		host.access(idx, 1'b1, 32'h0000_0000, 4'hf, got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: index %h read %h expected %h", $time, idx, got, exp);
		end
	endtask

	// Colour component as it stands in bits 7-2 of a readback word
	function automatic logic [DATA_W-1:0] cw(input logic [COLOR_W-1:0] c);
		return {24'h000000, c, 2'b00};
	endfunction

	task automatic chk_rgb(input logic [COLOR_W-1:0] b, input logic [COLOR_W-1:0] g,
		input logic [COLOR_W-1:0] r);
		chk(IDX_BLUE_READBACK, cw(b));
		chk(IDX_GREEN_READBACK, cw(g));
		chk(IDX_RED_READBACK, cw(r));
	endtask

	initial begin
		#(8 * 4000);
		miscompares++;
		finish_test();
	end

	initial begin
		logic [DATA_W-1:0] dummy;
		reset = 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		chk_rgb(6'h00, 6'h00, 6'h00);
		chk(IDX_WRITE_PTR, WORD_ZERO);
		chk(IDX_READ_PTR, WORD_ZERO);
		chk(6'h10, WORD_ZERO);
		// Stray bits outside the colour field must be dropped
		wr(IDX_BLUE_STAGE, 32'hffff_ffff);
		wr(IDX_GREEN_STAGE, 32'h0000_00a8);
		wr(IDX_RED_STAGE, 32'h0000_0057);
		wr(IDX_WRITE_PTR, 32'h0000_01ff);
		chk_rgb(6'h3f, 6'h2a, 6'h15);
		chk(IDX_WRITE_PTR, WORD_ZERO);
		wr(IDX_BLUE_STAGE, 32'h0000_0004);
		wr(IDX_GREEN_STAGE, 32'h0000_0008);
		wr(IDX_RED_STAGE, 32'h0000_000c);
		chk_rgb(6'h3f, 6'h2a, 6'h15);
		wr(IDX_BLUE_READBACK, 32'h0000_00ff);
		wr(IDX_RED_READBACK, 32'h0000_0000);
		chk_rgb(6'h3f, 6'h2a, 6'h15);
		wr(IDX_WRITE_PTR, 32'h0000_0000);
		chk_rgb(6'h01, 6'h02, 6'h03);
		wr(IDX_READ_PTR, 32'h0000_00ff);
		chk_rgb(6'h3f, 6'h2a, 6'h15);
		chk(IDX_READ_PTR, WORD_ZERO);
		wr(IDX_READ_PTR, 32'h0000_0080);
		chk_rgb(6'h00, 6'h00, 6'h00);
		// A write with lane 0 off leaves the staged blue untouched
		host.access(IDX_BLUE_STAGE, 1'b0, 32'h0000_00fc, 4'he, dummy);
		wr(IDX_WRITE_PTR, 32'h0000_0040);
		chk_rgb(6'h01, 6'h02, 6'h03);
		wr(IDX_READ_PTR, 32'h0000_0000);
		chk_rgb(6'h01, 6'h02, 6'h03);
		finish_test();
	end
endmodule // cplt_lut_regs_test
